/* adcc_regs.svh */
// Register map, field positions, reset values and counts of the calibration sequencer
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_IDX_CTRL 8'h00
`define ADCC_IDX_STATUS 8'h01
`define ADCC_IDX_TRIM_BASE 8'h10
`define ADCC_IDX_TRIM_LAST 8'h15
`define ADCC_IDX_SRC_DLY 8'h9A
`define ADCC_IDX_MUX_DLY 8'h9B

`define ADCC_CTRL_BG_EN 0
`define ADCC_CTRL_TRIG_SEL 1
`define ADCC_CTRL_SOFT_TRIG 2
`define ADCC_CTRL_FG_OFS 3
`define ADCC_CTRL_BG_OFS 4
`define ADCC_CTRL_VAR_LSB 5
`define ADCC_CTRL_VAR_MSB 6
`define ADCC_CTRL_WIDTH 7
`define ADCC_CTRL_RESET 7'h00

`define ADCC_DLY_RESET 8'h00
`define ADCC_MID_CODE 9'h000
`define ADCC_CORE_LAST 3'h5
`define ADCC_PHASE_CYCLES 16'h0100
`define ADCC_PHASE_LAST 16'h00FF

`define ADCC_CORE_A 3'h0
`define ADCC_CORE_B 3'h1
`define ADCC_CORE_SPARE0 3'h2
`define ADCC_CORE_SPARE1 3'h3
`define ADCC_CORE_C 3'h4
`define ADCC_CORE_D 3'h5

`endif

/* adcc_pkg.sv */
// Types shared by the calibration sequencer modules
package adcc_pkg;
   typedef enum logic [1:0] {ADCC_QUAD, ADCC_DUAL, ADCC_SINGLE, ADCC_RSVD} adcc_variant_t;
   typedef enum logic [1:0] {ADCC_PH_IDLE, ADCC_PH_LIN, ADCC_PH_GAIN, ADCC_PH_OFS} adcc_phase_t;
   typedef enum logic [3:0] {
      ADCC_S_LOAD, ADCC_S_FG_NEXT, ADCC_S_FG_WAIT, ADCC_S_IDLE,
      ADCC_S_BG_START, ADCC_S_BG_WAIT, ADCC_S_BG_SRC, ADCC_S_BG_MUX
   } adcc_state_t;
endpackage

/* adcc_core_cal.sv */
// One-core calibration engine: linearity, gain, then optional offset phase
`include "adcc_regs.svh"
module adcc_core_cal (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic use_ofs,
   output logic busy,
   output logic done,
   output logic ref_en,
   output adcc_pkg::adcc_phase_t phase
);
   import adcc_pkg::*;

   logic [15:0] cnt_q;
   wire logic last = (cnt_q == `ADCC_PHASE_LAST);
   wire logic fin = last && (phase == ADCC_PH_OFS || (phase == ADCC_PH_GAIN && !use_ofs));

   // Reference stays applied for the whole run of the core
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= ADCC_PH_IDLE;
         cnt_q <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
         ref_en <= 1'b0;
      end else begin
         done <= 1'b0;
         if (phase == ADCC_PH_IDLE) begin
            if (start) begin
               phase <= ADCC_PH_LIN;
               busy <= 1'b1;
               ref_en <= 1'b1;
               cnt_q <= 16'h0000;
            end
         end else if (fin) begin
            phase <= ADCC_PH_IDLE;
            busy <= 1'b0;
            ref_en <= 1'b0;
            done <= 1'b1;
         end else if (last) begin
            phase <= (phase == ADCC_PH_LIN) ? ADCC_PH_GAIN : ADCC_PH_OFS;
            cnt_q <= 16'h0000;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule

/* adcc_cal_seq.sv */
// Calibration sequencer for the six converter cores, with Avalon-MM registers
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "adcc_regs.svh"
// Contract
// - Foreground run holds cores offline and outputs mid-code zero until done.
// - Foreground routing: channels A, B, C, D on cores 0, 1, 4, 5.
// - Quad background: core 2 replaces 0 or 1, core 3 replaces 4 or 5.
// - Dual: cores 0 and 1 share core 2; single: core 0 spares with 2.
// - Calibrated spare takes over next active core, which is calibrated next in its own group, forever.
// - Never more than one core under calibration at once.
// - Background mode keeps sample output continuous during exchanges.
// - Foreground calibration runs after power-up; host waits before configuring.
// - Foreground starts on pin or software trigger, chosen by source select.
// - Calibration trims linearity, gain, offset against internal reference; inputs may run.
// - Trims load factory values, are readable, and host writes override them.
module adcc_cal_seq (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cal_trigger_pin,
   input wire logic sample_tick,
   input wire logic [8:0] core0_data,
   input wire logic [8:0] core1_data,
   input wire logic [8:0] core2_data,
   input wire logic [8:0] core3_data,
   input wire logic [8:0] core4_data,
   input wire logic [8:0] core5_data,
   output logic [2:0] fuse_addr,
   input wire logic [23:0] fuse_data,
   output logic [8:0] chan_a_data,
   output logic [8:0] chan_b_data,
   output logic [8:0] chan_c_data,
   output logic [8:0] chan_d_data,
   output logic [5:0] core_online,
   output logic [5:0] core_cal_sel,
   output logic cal_ref_en,
   output adcc_pkg::adcc_phase_t cal_phase,
   output logic spare0_src,
   output logic spare1_src,
   output logic trim_wr_stb,
   output logic [2:0] trim_wr_core,
   output logic [23:0] trim_wr_data
);
   import adcc_pkg::*;

   function automatic logic core_present(input adcc_variant_t v, input logic [2:0] idx);
      core_present = (v == ADCC_QUAD) ||
         (v == ADCC_DUAL && idx <= `ADCC_CORE_SPARE0) ||
         (v != ADCC_DUAL && idx == `ADCC_CORE_A) ||
         (v != ADCC_DUAL && idx == `ADCC_CORE_SPARE0);
   endfunction

   function automatic logic [5:0] onehot(input logic [2:0] idx);
      onehot = 6'h01 << idx;
   endfunction

   // Registers
   logic [`ADCC_CTRL_WIDTH-1:0] ctrl_q;
   logic [7:0] src_dly_q;
   logic [7:0] mux_dly_q;
   logic [23:0] trim_q [6];
   logic fg_done_q;

   // Sequencer state
   adcc_state_t state_q;
   logic [2:0] idx_q;
   logic [7:0] dly_q;
   logic trig_q;
   logic start_q;
   logic [2:0] srv_a_q, srv_b_q, srv_c_q, srv_d_q, spare0_q, spare1_q;
   logic grp_q, alt0_q, alt1_q;
   logic [2:0] cal_core_q;

   wire adcc_variant_t variant = adcc_variant_t'(ctrl_q[`ADCC_CTRL_VAR_MSB:`ADCC_CTRL_VAR_LSB]);
   wire logic trig_sel = ctrl_q[`ADCC_CTRL_TRIG_SEL];
   wire logic soft_trig = ctrl_q[`ADCC_CTRL_SOFT_TRIG];
   wire logic bg_en = ctrl_q[`ADCC_CTRL_BG_EN];
   wire logic trig = trig_sel ? cal_trigger_pin : soft_trig;
   wire logic trig_rise = trig && !trig_q;
   wire logic bg_run = bg_en && !trig_sel && soft_trig;
   wire logic in_fg = (state_q == ADCC_S_FG_NEXT) || (state_q == ADCC_S_FG_WAIT) ||
      (state_q == ADCC_S_LOAD);

   // Engine and its offset phase selection
   logic eng_busy, eng_done, eng_ref;
   adcc_phase_t eng_phase;
   wire logic use_ofs = in_fg ? ctrl_q[`ADCC_CTRL_FG_OFS] : ctrl_q[`ADCC_CTRL_BG_OFS];

   adcc_core_cal u_cal (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .start(start_q),
      .use_ofs(use_ofs),
      .busy(eng_busy),
      .done(eng_done),
      .ref_en(eng_ref),
      .phase(eng_phase)
   );

   // Background target: group 0 is A/B with spare0, group 1 is C/D with spare1
   wire logic tgt0_b = (variant != ADCC_SINGLE) && alt0_q;
   wire logic [2:0] grp_spare = grp_q ? spare1_q : spare0_q;
   wire logic grp_next = (variant == ADCC_QUAD) ? !grp_q : 1'b0;

   // Core data routing
   wire logic [8:0] core_arr [6];
   assign core_arr[0] = core0_data;
   assign core_arr[1] = core1_data;
   assign core_arr[2] = core2_data;
   assign core_arr[3] = core3_data;
   assign core_arr[4] = core4_data;
   assign core_arr[5] = core5_data;
   wire logic [8:0] mux_a = in_fg ? `ADCC_MID_CODE : core_arr[srv_a_q];
   wire logic [8:0] mux_b = in_fg ? `ADCC_MID_CODE : core_arr[srv_b_q];
   wire logic [8:0] mux_c = in_fg ? `ADCC_MID_CODE : core_arr[srv_c_q];
   wire logic [8:0] mux_d = in_fg ? `ADCC_MID_CODE : core_arr[srv_d_q];
   wire logic [5:0] present_mask = {core_present(variant, 3'h5), core_present(variant, 3'h4),
      core_present(variant, 3'h3), core_present(variant, 3'h2),
      core_present(variant, 3'h1), core_present(variant, 3'h0)};
   // Absent cores of the smaller variants never count as online
   wire logic [5:0] online_d = in_fg ? 6'h00 :
      (onehot(srv_a_q) | onehot(srv_c_q) | onehot(srv_b_q) | onehot(srv_d_q)) &
      ~(eng_busy ? onehot(cal_core_q) : 6'h00) & present_mask;

   // Bus decode
   wire logic acc = (avs_read || avs_write) && avs_waitrequest;
   wire logic commit_wr = avs_write && !avs_waitrequest;
   wire logic hit_ctrl = (avs_address == `ADCC_IDX_CTRL);
   wire logic hit_status = (avs_address == `ADCC_IDX_STATUS);
   wire logic hit_src = (avs_address == `ADCC_IDX_SRC_DLY);
   wire logic hit_mux = (avs_address == `ADCC_IDX_MUX_DLY);
   wire logic hit_trim = (avs_address >= `ADCC_IDX_TRIM_BASE) &&
      (avs_address <= `ADCC_IDX_TRIM_LAST);
   wire logic [2:0] trim_idx = 3'(avs_address - `ADCC_IDX_TRIM_BASE);
   wire logic [31:0] status_word = {16'h0000, grp_q, cal_core_q, eng_busy, online_d,
      state_q, fg_done_q};
   logic [31:0] rd_mux;
   always_comb begin
      if (hit_ctrl) begin
         rd_mux = {25'h0, ctrl_q};
      end else if (hit_status) begin
         rd_mux = status_word;
      end else if (hit_src) begin
         rd_mux = {24'h000000, src_dly_q};
      end else if (hit_mux) begin
         rd_mux = {24'h000000, mux_dly_q};
      end else if (hit_trim) begin
         rd_mux = {8'h00, trim_q[trim_idx]};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   // One wait state per access; read data is captured on the edge that ends the wait, writes land one edge later
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= !acc;
         if (acc && avs_read) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `ADCC_CTRL_RESET;
         src_dly_q <= `ADCC_DLY_RESET;
         mux_dly_q <= `ADCC_DLY_RESET;
      end else if (commit_wr) begin
         if (hit_ctrl) begin
            ctrl_q <= avs_writedata[`ADCC_CTRL_WIDTH-1:0];
         end else if (hit_src) begin
            src_dly_q <= avs_writedata[7:0];
         end else if (hit_mux) begin
            mux_dly_q <= avs_writedata[7:0];
         end
      end
   end

   // Trims: factory load after reset, host writes override
   always_ff @(posedge core_clk) begin
      if (state_q == ADCC_S_LOAD) begin
         trim_q[fuse_addr] <= fuse_data;
      end else if (commit_wr && hit_trim) begin
         trim_q[trim_idx] <= avs_writedata[23:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_wr_stb <= 1'b0;
         trim_wr_core <= 3'h0;
         trim_wr_data <= 24'h000000;
      end else begin
         trim_wr_stb <= (state_q == ADCC_S_LOAD) || (commit_wr && hit_trim);
         trim_wr_core <= (state_q == ADCC_S_LOAD) ? fuse_addr : trim_idx;
         trim_wr_data <= (state_q == ADCC_S_LOAD) ? fuse_data : avs_writedata[23:0];
      end
   end

   // Output samples advance on sample boundaries only
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_a_data <= `ADCC_MID_CODE;
         chan_b_data <= `ADCC_MID_CODE;
         chan_c_data <= `ADCC_MID_CODE;
         chan_d_data <= `ADCC_MID_CODE;
         core_online <= 6'h00;
         core_cal_sel <= 6'h00;
         cal_ref_en <= 1'b0;
         cal_phase <= ADCC_PH_IDLE;
      end else begin
         if (sample_tick) begin
            chan_a_data <= mux_a;
            chan_b_data <= mux_b;
            chan_c_data <= mux_c;
            chan_d_data <= mux_d;
         end
         core_online <= online_d;
         core_cal_sel <= eng_busy ? onehot(cal_core_q) : 6'h00;
         cal_ref_en <= eng_ref;
         cal_phase <= eng_phase;
      end
   end

   // Sequencer
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ADCC_S_LOAD;
         fuse_addr <= 3'h0;
         idx_q <= 3'h0;
         dly_q <= 8'h00;
         trig_q <= 1'b0;
         start_q <= 1'b0;
         fg_done_q <= 1'b0;
         cal_core_q <= 3'h0;
         srv_a_q <= `ADCC_CORE_A;
         srv_b_q <= `ADCC_CORE_B;
         srv_c_q <= `ADCC_CORE_C;
         srv_d_q <= `ADCC_CORE_D;
         spare0_q <= `ADCC_CORE_SPARE0;
         spare1_q <= `ADCC_CORE_SPARE1;
         spare0_src <= 1'b0;
         spare1_src <= 1'b0;
         grp_q <= 1'b0;
         alt0_q <= 1'b0;
         alt1_q <= 1'b0;
      end else begin
         trig_q <= trig;
         start_q <= 1'b0;
         case (state_q)
            ADCC_S_LOAD: begin
               fuse_addr <= fuse_addr + 3'h1;
               if (fuse_addr == `ADCC_CORE_LAST) begin
                  fuse_addr <= 3'h0;
                  idx_q <= 3'h0;
                  state_q <= ADCC_S_FG_NEXT;
               end
            end
            ADCC_S_FG_NEXT: begin
               if (present_mask[idx_q]) begin
                  cal_core_q <= idx_q;
                  start_q <= 1'b1;
                  state_q <= ADCC_S_FG_WAIT;
               end else if (idx_q == `ADCC_CORE_LAST) begin
                  fg_done_q <= 1'b1;
                  state_q <= ADCC_S_IDLE;
               end else begin
                  idx_q <= idx_q + 3'h1;
               end
            end
            ADCC_S_FG_WAIT: begin
               if (eng_done) begin
                  if (idx_q == `ADCC_CORE_LAST) begin
                     fg_done_q <= 1'b1;
                     state_q <= ADCC_S_IDLE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                     state_q <= ADCC_S_FG_NEXT;
                  end
               end
            end
            ADCC_S_IDLE: begin
               if (bg_run) begin
                  state_q <= ADCC_S_BG_START;
               end else if (trig_rise) begin
                  fg_done_q <= 1'b0;
                  idx_q <= 3'h0;
                  srv_a_q <= `ADCC_CORE_A;
                  srv_b_q <= `ADCC_CORE_B;
                  srv_c_q <= `ADCC_CORE_C;
                  srv_d_q <= `ADCC_CORE_D;
                  spare0_q <= `ADCC_CORE_SPARE0;
                  spare1_q <= `ADCC_CORE_SPARE1;
                  grp_q <= 1'b0;
                  alt0_q <= 1'b0;
                  alt1_q <= 1'b0;
                  spare0_src <= 1'b0;
                  spare1_src <= 1'b0;
                  state_q <= ADCC_S_FG_NEXT;
               end
            end
            ADCC_S_BG_START: begin
               cal_core_q <= grp_spare;
               start_q <= 1'b1;
               state_q <= ADCC_S_BG_WAIT;
            end
            ADCC_S_BG_WAIT: begin
               if (eng_done) begin
                  dly_q <= src_dly_q;
                  state_q <= ADCC_S_BG_SRC;
               end
            end
            ADCC_S_BG_SRC: begin
               // Spare starts sampling the target channel before it is muxed in
               if (dly_q == 8'h00) begin
                  if (grp_q) begin
                     spare1_src <= alt1_q;
                  end else begin
                     spare0_src <= tgt0_b;
                  end
                  dly_q <= mux_dly_q;
                  state_q <= ADCC_S_BG_MUX;
               end else begin
                  dly_q <= dly_q - 8'h01;
               end
            end
            ADCC_S_BG_MUX: begin
               if (dly_q != 8'h00) begin
                  dly_q <= dly_q - 8'h01;
               end else if (sample_tick) begin
                  if (grp_q) begin
                     if (alt1_q) begin
                        srv_d_q <= spare1_q;
                        spare1_q <= srv_d_q;
                     end else begin
                        srv_c_q <= spare1_q;
                        spare1_q <= srv_c_q;
                     end
                     alt1_q <= !alt1_q;
                  end else begin
                     if (tgt0_b) begin
                        srv_b_q <= spare0_q;
                        spare0_q <= srv_b_q;
                     end else begin
                        srv_a_q <= spare0_q;
                        spare0_q <= srv_a_q;
                     end
                     alt0_q <= !alt0_q;
                  end
                  grp_q <= grp_next;
                  state_q <= bg_run ? ADCC_S_BG_START : ADCC_S_IDLE;
               end
            end
            default: begin
               state_q <= ADCC_S_IDLE;
            end
         endcase
      end
   end
endmodule

/* adcc_core_model.sv */
// Converter core samples, sample boundary and factory trim store
module adcc_core_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [2:0] fuse_addr,
   output logic sample_tick,
   output logic [5:0][8:0] core_data,
   output logic [23:0] fuse_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_q;
   logic [5:0] cnt_q;
   assign sample_tick = div_q == 2'h3;
   // Distinct factory word per core
   assign fuse_data = {5'h00, fuse_addr, 8'h9C, 5'h0C, fuse_addr};
   // Core id in top bits keeps every sample nonzero
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         core_data[i] = {3'(i + 1), cnt_q};
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= 2'h0;
         cnt_q <= 6'h00;
      end else begin
         div_q <= div_q + 2'h1;
         cnt_q <= cnt_q + {5'h00, sample_tick};
      end
   end
endmodule

/* adcc_cal_seq_assertions.sv */
// Port-level checks of the calibration sequencer
module adcc_seq_chk (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic sample_tick,
   input wire logic [8:0] core0_data,
   input wire logic [8:0] core1_data,
   input wire logic [8:0] core2_data,
   input wire logic [8:0] chan_a_data,
   input wire logic [5:0] core_online,
   input wire logic [5:0] core_cal_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   chk_one_cal: assert property ($countones(core_cal_sel) <= 1)
      else $error("several cores calibrating");
   chk_cal_off: assert property ((core_online & core_cal_sel) == 6'h00)
      else $error("calibrating core still online");
   chk_mid_code: assert property (
      sample_tick && core_online == 6'h00 ##1 core_online == 6'h00 |-> chan_a_data == 9'h000)
      else $error("output not mid-code in foreground");
   chk_hold_tick: assert property (
      !sample_tick |=> $stable(chan_a_data))
      else $error("channel changed off a sample boundary");
   chk_a_source: assert property (
      sample_tick && core_online[2:0] != 3'h0 ##1 core_online[2:0] != 3'h0
      |-> chan_a_data == $past(core0_data) || chan_a_data == $past(core1_data)
      || chan_a_data == $past(core2_data))
      else $error("channel a not from its core group");
   chk_swap_tick: assert property (
      core_online != 6'h00 && $past(core_online) != 6'h00 && core_online != $past(core_online)
      && $countones(core_online) == $countones($past(core_online)) |-> $past(sample_tick, 2))
      else $error("core exchange off a sample boundary");
   chk_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered after one wait state");
   chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
endmodule
bind adcc_cal_seq adcc_seq_chk u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .sample_tick(sample_tick), .core0_data(core0_data),
   .core1_data(core1_data), .core2_data(core2_data), .chan_a_data(chan_a_data),
   .core_online(core_online), .core_cal_sel(core_cal_sel));

/* testbench.sv */
// Self-checking bench of the calibration sequencer
`include "adcc_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic cal_trigger_pin = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, sample_tick, cal_ref_en, trim_wr_stb, spare0_src, spare1_src;
   logic [5:0][8:0] core_data;
   logic [2:0] fuse_addr, trim_wr_core, seen_core;
   logic [23:0] fuse_data, trim_wr_data, seen_data;
   logic [8:0] chan_a_data, chan_b_data, chan_c_data, chan_d_data;
   logic [5:0] core_online, core_cal_sel;
   adcc_phase_t cal_phase;
   int fail_count = 0;
   int tests_run = 0;
   always #4 core_clk = ~core_clk;
   adcc_core_model u_model (.core_clk(core_clk), .rst_b(rst_b), .fuse_addr(fuse_addr),
      .sample_tick(sample_tick), .core_data(core_data), .fuse_data(fuse_data));
   adcc_cal_seq DUT (
      .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cal_trigger_pin(cal_trigger_pin),
      .sample_tick(sample_tick), .core0_data(core_data[0]), .core1_data(core_data[1]),
      .core2_data(core_data[2]), .core3_data(core_data[3]), .core4_data(core_data[4]),
      .core5_data(core_data[5]), .fuse_addr(fuse_addr), .fuse_data(fuse_data),
      .chan_a_data(chan_a_data), .chan_b_data(chan_b_data), .chan_c_data(chan_c_data),
      .chan_d_data(chan_d_data), .core_online(core_online), .core_cal_sel(core_cal_sel),
      .cal_ref_en(cal_ref_en), .cal_phase(cal_phase), .spare0_src(spare0_src),
      .spare1_src(spare1_src),
      .trim_wr_stb(trim_wr_stb), .trim_wr_core(trim_wr_core), .trim_wr_data(trim_wr_data));
   always @(posedge core_clk) begin
      if (trim_wr_stb === 1'b1) begin
         seen_core <= trim_wr_core;
         seen_data <= trim_wr_data;
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic bus_access(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) check("bus answer", 32'h0, 32'h1);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_access(1'b1, a, d, q);
   endtask
   task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus_access(1'b0, a, 32'h0, q);
      check(what, exp, q);
   endtask
   task automatic poll_status(input logic [31:0] msk, input logic [31:0] val);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         bus_access(1'b0, `ADCC_IDX_STATUS, 32'h0, q);
         n++;
      end while ((q & msk) !== val && n < 5000);
      check("status", val, q & msk);
   endtask
   task automatic wait_online(input logic [5:0] m);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (core_online !== m && n < 20);
      check("online", {26'h0, m}, {26'h0, core_online});
   endtask
   task automatic t_power_up();
      repeat (200) @(posedge core_clk);
      @(negedge core_clk);
      check("online", 32'h0, {26'h0, core_online});
      check("chan a", 32'h0, {23'h0, chan_a_data});
      check("one core", 32'h1, {31'h0, $onehot(core_cal_sel)});
      check("reference", 32'h1, {31'h0, cal_ref_en});
      check("phase", {30'h0, ADCC_PH_LIN}, {30'h0, cal_phase});
      poll_status(32'h1, 32'h1);
      wait_online(6'h33);
   endtask
   task automatic t_registers();
      reg_check("src dly", `ADCC_IDX_SRC_DLY, 32'h0);
      reg_check("mux dly", `ADCC_IDX_MUX_DLY, 32'h0);
      reg_write(`ADCC_IDX_SRC_DLY, 32'hFFFFFF1F);
      reg_write(`ADCC_IDX_MUX_DLY, 32'h0000001E);
      reg_check("src dly", `ADCC_IDX_SRC_DLY, 32'h1F);
      reg_check("mux dly", `ADCC_IDX_MUX_DLY, 32'h1E);
      reg_write(8'h50, 32'hFFFFFFFF);
      reg_check("unmapped", 8'h50, 32'h0);
      for (int i = 0; i < 6; i++) begin
         reg_check("trim", `ADCC_IDX_TRIM_BASE + 8'(i), {13'h0, 3'(i), 13'h138C, 3'(i)});
      end
      reg_write(`ADCC_IDX_TRIM_BASE + 8'h02, 32'h00ABCDEF);
      repeat (4) @(posedge core_clk);
      check("trim core", 32'h2, {29'h0, seen_core});
      check("trim data", 32'h00ABCDEF, {8'h0, seen_data});
      reg_check("trim", `ADCC_IDX_TRIM_BASE + 8'h02, 32'h00ABCDEF);
   endtask
   task automatic t_routing();
      logic [8:0] ea, eb, ec, ed;
      do @(negedge core_clk); while (sample_tick !== 1'b1);
      ea = core_data[0];
      eb = core_data[1];
      ec = core_data[4];
      ed = core_data[5];
      @(negedge core_clk);
      check("chan a", {23'h0, ea}, {23'h0, chan_a_data});
      check("chan b", {23'h0, eb}, {23'h0, chan_b_data});
      check("chan c", {23'h0, ec}, {23'h0, chan_c_data});
      check("chan d", {23'h0, ed}, {23'h0, chan_d_data});
   endtask
   task automatic t_triggers();
      reg_write(`ADCC_IDX_CTRL, 32'h00000006);
      repeat (20) @(posedge core_clk);
      wait_online(6'h33);
      @(posedge core_clk);
      cal_trigger_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      cal_trigger_pin <= 1'b0;
      wait_online(6'h00);
      poll_status(32'h1, 32'h1);
      wait_online(6'h33);
      reg_write(`ADCC_IDX_CTRL, 32'h0);
      reg_write(`ADCC_IDX_CTRL, 32'h00000004);
      wait_online(6'h00);
      poll_status(32'h1, 32'h1);
      wait_online(6'h33);
   endtask
   task automatic t_background(input logic [1:0] v, input logic [5:0] m, input logic [5:0] idle);
      logic [31:0] ctl;
      logic spare_in, act_cal, stray, s0, s1;
      ctl = {25'h0, v, 5'h00};
      reg_write(`ADCC_IDX_CTRL, ctl);
      poll_status(32'h1E, {27'h0, ADCC_S_IDLE, 1'b0});
      reg_write(`ADCC_IDX_CTRL, ctl | 32'h4);
      wait_online(6'h00);
      poll_status(32'h1, 32'h1);
      wait_online(idle);
      reg_write(`ADCC_IDX_CTRL, ctl | 32'h5);
      reg_check("control", `ADCC_IDX_CTRL, ctl | 32'h5);
      spare_in = 1'b0;
      act_cal = 1'b0;
      stray = 1'b0;
      s0 = 1'b0;
      s1 = 1'b0;
      repeat (2600) begin
         @(negedge core_clk);
         s0 |= spare0_src;
         s1 |= spare1_src;
         spare_in |= core_online[2] | core_online[3];
         act_cal |= |(core_cal_sel & m & 6'h33);
         stray |= |((core_online | core_cal_sel) & ~m) | (chan_a_data === 9'h000)
            | ($countones(core_online) != $countones(idle));
      end
      check("spare in service", 32'h1, {31'h0, spare_in});
      check("active core calibrated", 32'h1, {31'h0, act_cal});
      check("cores and output", 32'h0, {31'h0, stray});
      check("spare0 tracks b", {31'h0, v != 2'h2}, {31'h0, s0});
      check("spare1 tracks d", {31'h0, v == 2'h0}, {31'h0, s1});
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      t_power_up();
      t_registers();
      t_routing();
      t_triggers();
      t_background(2'h0, 6'h3F, 6'h33);
      t_background(2'h1, 6'h07, 6'h03);
      t_background(2'h2, 6'h05, 6'h01);
      tally_and_finish();
   end
endmodule
